//--- fesa_bus_if.sv
// Interface: one bus cycle request between sequencer and pin driver
`default_nettype none
interface fesa_bus_if;
	logic        req;
	logic        wr;
	logic        hv_oe;
	logic        hv_ce;
	logic        hv_id;
	logic [16:0] addr;
	logic [7:0]  wdata;
	logic        done;
	logic [7:0]  rdata;
	modport seq (output req, wr, hv_oe, hv_ce, hv_id, addr, wdata, input done, rdata);
	modport pins (input req, wr, hv_oe, hv_ce, hv_id, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

//--- fesa_flash_model.sv
// Flash device model: command decode, status bits, boot lock, id codes
`default_nettype none
module fesa_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'h3c, // Arbitrary value
	parameter int         POLLS      = 6
) (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        hv_oe,
	input  wire logic        hv_ce,
	input  wire logic        hv_id,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  dq_out,
	output logic [7:0]       dq_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [24:0] seq [6] = '{25'h05555aa, 25'h02aaa55, 25'h0555580, 25'h05555aa,
		25'h02aaa55, 25'h0555510};
	logic [16:0] lat_a = 17'h0;
	logic [7:0]  last = 8'h0, rd;
	logic [2:0]  step = 3'h0;
	logic        auto_on = 1'h0, locked = 1'h0, erasing = 1'h0, tgl = 1'h0, wr_open = 1'h0;
	int          polls_left = 0, erase_cnt = 0;
	time         t_fall = 0;
	// address on later fall, lock by high voltage
	always @(negedge we_n or negedge ce_n) begin
		if (!we_n && !ce_n) begin
			lat_a = addr;
			t_fall = $time;
			wr_open = 1'h1;
		end
		if (!we_n && hv_oe && hv_id)
			locked = hv_ce ? 1'h0 : (!ce_n ? 1'h1 : locked);
	end
	// command byte on first rise; noise and erase ignore it
	always @(posedge we_n or posedge ce_n) begin
		if (wr_open && ($time - t_fall) >= 5 && oe_n && !hv_oe && !erasing) begin
			if (dq_out == 8'hf0) begin
				auto_on = 1'h0;
				step = 3'h0;
			end else if (step == 3'h2 && {lat_a, dq_out} == 25'h0555590) begin
				auto_on = 1'h1;
				step = 3'h0;
			end else if ({lat_a, dq_out} == seq[step]) step = step + 3'h1;
			else step = 3'h0;
			if (step == 3'h6) begin
				step = 3'h0;
				erasing = 1'h1;
				polls_left = POLLS;
				erase_cnt++;
			end
		end
		wr_open = 1'h0;
	end
	// each read flips toggle until erase ends; no change after
	always @(negedge oe_n) begin
		if (erasing) begin
			tgl = !tgl;
			polls_left--;
			if (polls_left == 0) erasing = 1'h0;
		end
	end
	always @* begin
		if (hv_id || auto_on) rd = addr[1] ? {7'h0, locked} : (addr[0] ? DEV_CODE : MAKER_CODE);
		else if (erasing) rd = {1'h0, tgl, 6'h3f};
		else rd = 8'hff;
	end
	// Released bus shows the inverse of the last byte, never a stale copy
	always @* if (!ce_n && !oe_n) last = rd;
	assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
endmodule
`default_nettype wire

//--- fesa_host.sv
// Host controller: chip erase, status polling, boot lock and autoselect reads
`default_nettype none
module fesa_host (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic         start,
	input  wire fesa_pkg::fesa_op_t op,
	input  wire logic         top_boot,
	output logic              busy,
	output logic              done,
	output logic [7:0]        result,
	output logic              erase_ok,
	output logic              ce_n,
	output logic              oe_n,
	output logic              we_n,
	output logic              hv_oe,
	output logic              hv_ce,
	output logic              hv_id,
	output logic [16:0]       addr,
	output logic [7:0]        dq_out,
	output logic              dq_oe,
	input  wire logic [7:0]   dq_in
);
	typedef enum logic [2:0] {
		FESA_IDLE, FESA_CMD, FESA_POLL, FESA_VERIFY, FESA_ONE, FESA_FIN, FESA_EXIT
	} fesa_st_t;
	typedef struct packed {
		fesa_st_t            st;
		fesa_pkg::fesa_op_t  op;
		logic [2:0]          step;
		logic                req;
		logic                prev_tog;
		logic                have_prev;
		logic                busy, done, erase_ok;
		logic [7:0]          result;
		logic [16:0]         vaddr;
	} fesa_t;
	fesa_t s_r, s_nxt;
	fesa_bus_if bus ();

	// Command table: address and data for one write of a sequence
	function automatic logic [24:0] cmd_word(input fesa_pkg::fesa_op_t o, input logic [2:0] i);
		logic [7:0] last;
		last = (o == fesa_pkg::FESA_OP_ERASE) ? fesa_pkg::CMD_ERASE_SETUP
			: fesa_pkg::CMD_AUTOSELECT;
		unique case (i)
			3'h0, 3'h3: cmd_word = {fesa_pkg::UNLOCK_ADDR_1, fesa_pkg::UNLOCK_DATA_1};
			3'h1, 3'h4: cmd_word = {fesa_pkg::UNLOCK_ADDR_2, fesa_pkg::UNLOCK_DATA_2};
			3'h2: cmd_word = {fesa_pkg::UNLOCK_ADDR_1, last};
			default: cmd_word = {fesa_pkg::UNLOCK_ADDR_1, fesa_pkg::CMD_CHIP_ERASE};
		endcase
	endfunction

	// Number of writes each command needs
	function automatic logic [2:0] cmd_len(input fesa_pkg::fesa_op_t o);
		cmd_len = (o == fesa_pkg::FESA_OP_ERASE) ? 3'h6 : 3'h3;
	endfunction

	fesa_pin_cycle u_pins (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.bus     (bus),
		.ce_n    (ce_n),
		.oe_n    (oe_n),
		.we_n    (we_n),
		.hv_oe   (hv_oe),
		.hv_ce   (hv_ce),
		.hv_id   (hv_id),
		.addr    (addr),
		.dq_out  (dq_out),
		.dq_oe   (dq_oe),
		.dq_in   (dq_in)
	);

	assign busy = s_r.busy;
	assign done = s_r.done;
	assign result = s_r.result;
	assign erase_ok = s_r.erase_ok;

	logic [24:0] cw;
	logic        tog_now;
	assign cw = cmd_word(s_r.op, s_r.step);
	assign tog_now = bus.rdata[fesa_pkg::TOGGLE_BIT];

	// Request fields presented to the pin driver
	always_comb begin
		bus.req = s_r.req;
		bus.wr = 1'b0;
		bus.hv_oe = 1'b0;
		bus.hv_ce = 1'b0;
		bus.hv_id = 1'b0;
		bus.addr = s_r.vaddr;
		bus.wdata = '0;
		unique case (s_r.st)
			// six ordered writes for erase, three for soft id
			FESA_CMD: begin
				bus.wr = 1'b1;
				bus.addr = cw[24:8];
				bus.wdata = cw[7:0];
			end
			// lock with high voltage on OE and id pin, CE and WE low
			// unlock adds high voltage on CE
			// high-voltage id mode held only while id pin is high; soft id keeps the pin low
			FESA_ONE: begin
				bus.hv_id = (s_r.op != fesa_pkg::FESA_OP_SW_ID);
				bus.wr = (s_r.op == fesa_pkg::FESA_OP_LOCK) ||
					(s_r.op == fesa_pkg::FESA_OP_UNLOCK);
				bus.hv_oe = bus.wr;
				bus.hv_ce = (s_r.op == fesa_pkg::FESA_OP_UNLOCK);
			end
			// Soft id leaves the device in id mode until a reset command
			FESA_EXIT: begin
				bus.wr = 1'b1;
				bus.addr = fesa_pkg::UNLOCK_ADDR_1;
				bus.wdata = fesa_pkg::CMD_READ_RESET;
			end
			default: ;
		endcase
	end

	// Operation sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.req = 1'b0;
		unique case (s_r.st)
			FESA_IDLE: begin
				if (start) begin
					s_nxt.op = op;
					s_nxt.busy = 1'b1;
					s_nxt.step = fesa_pkg::STEP_ZERO;
					s_nxt.req = 1'b1;
					s_nxt.have_prev = 1'b0;
					// pick boot status address by variant
					// bit zero high selects device code
					unique case (op)
						fesa_pkg::FESA_OP_READ_ID, fesa_pkg::FESA_OP_SW_ID:
							s_nxt.vaddr = top_boot ? fesa_pkg::ID_DEVICE_ADDR
								: fesa_pkg::ID_MAKER_ADDR;
						fesa_pkg::FESA_OP_READ_PROT:
							s_nxt.vaddr = top_boot ? fesa_pkg::PROT_TOP_ADDR
								: fesa_pkg::PROT_BOT_ADDR;
						default: s_nxt.vaddr = '0;
					endcase
					s_nxt.st = (op == fesa_pkg::FESA_OP_ERASE || op == fesa_pkg::FESA_OP_SW_ID)
						? FESA_CMD : FESA_ONE;
				end
			end
			FESA_CMD: begin
				if (bus.done) begin
					s_nxt.req = 1'b1;
					s_nxt.step = s_r.step + fesa_pkg::STEP_ONE;
					if (s_r.step + fesa_pkg::STEP_ONE == cmd_len(s_r.op)) begin
						// erase runs from last rising strobe, poll it
						// soft id read follows the command
						// maker code with bit zero low
						s_nxt.st = (s_r.op == fesa_pkg::FESA_OP_ERASE) ? FESA_POLL : FESA_ONE;
					end
				end
			end
			FESA_POLL: begin
				// no program is issued while the erase runs
				if (bus.done) begin
					s_nxt.have_prev = 1'b1;
					s_nxt.prev_tog = tog_now;
					// a flip between reads means still busy
					// equal reads mean the cycle has ended
					// poll bit low stays busy; high is done
					if (s_r.have_prev && tog_now == s_r.prev_tog &&
						bus.rdata[fesa_pkg::POLL_BIT]) begin
						s_nxt.vaddr = '0;
						s_nxt.erase_ok = 1'b1;
						s_nxt.st = FESA_VERIFY;
					end
					s_nxt.req = 1'b1;
				end
			end
			FESA_VERIFY: begin
				// every byte must read all ones
				// sector order is internal, host only checks result
				// zero preprogram is internal, not host driven
				if (bus.done) begin
					if (bus.rdata != 8'hff)
						s_nxt.erase_ok = 1'b0;
					if (s_r.vaddr == '1) begin
						s_nxt.result = bus.rdata;
						s_nxt.st = FESA_FIN;
					end else begin
						s_nxt.vaddr = s_r.vaddr + 17'h00001;
						s_nxt.req = 1'b1;
					end
				end
			end
			FESA_ONE: begin
				// protection read gives zero when unprotected
				// strobes are many cycles, never a noise pulse
				// OE kept high on every write
				if (bus.done) begin
					s_nxt.result = bus.rdata;
					s_nxt.req = (s_r.op == fesa_pkg::FESA_OP_SW_ID);
					s_nxt.st = (s_r.op == fesa_pkg::FESA_OP_SW_ID) ? FESA_EXIT : FESA_FIN;
				end
			end
			// Reset command written; later status polls see real data
			FESA_EXIT: begin
				if (bus.done)
					s_nxt.st = FESA_FIN;
			end
			FESA_FIN: begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = FESA_IDLE;
			end
			default: s_nxt.st = FESA_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{st: FESA_IDLE, op: fesa_pkg::FESA_OP_ERASE, step: fesa_pkg::STEP_ZERO,
				req: 1'b0, prev_tog: 1'b0, have_prev: 1'b0, busy: 1'b0, done: 1'b0,
				erase_ok: 1'b0, result: '0, vaddr: '0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

//--- fesa_host_chk.sv
// Checker: pin timing and bus discipline of the flash host
`default_nettype none
module fesa_host_chk (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic        hv_oe,
	input wire logic        hv_ce,
	input wire logic        hv_id,
	input wire logic [16:0] addr,
	input wire logic [7:0]  dq_out,
	input wire logic        dq_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Write pulse opens, then must stay low
	sequence s_wr_open;
		$fell(we_n);
	endsequence
	sequence s_wr_held;
		!we_n [*5];
	endsequence
	AST_WR_WIDTH: assert property (s_wr_open |-> s_wr_held)
		else $error("write pulse too short");
	AST_WR_NO_OE: assert property (!we_n && !hv_oe |-> oe_n)
		else $error("write strobe with output enable low");
	AST_WR_DATA: assert property (!we_n && !hv_oe |-> dq_oe)
		else $error("write without data driven");
	AST_RD_FREE: assert property (!oe_n |-> !dq_oe)
		else $error("host drives data during read");
	AST_WR_STABLE: assert property (!we_n && $past(!we_n) |-> $stable(addr) && $stable(dq_out))
		else $error("address or data moved in write");
	AST_UNLOCK2: assert property (s_wr_open ##0 addr == fesa_pkg::UNLOCK_ADDR_2
		|-> dq_out == fesa_pkg::UNLOCK_DATA_2)
		else $error("wrong second unlock byte");
	AST_HV_UNLOCK: assert property (hv_ce |-> hv_oe && hv_id)
		else $error("high voltage on select alone");
	AST_HV_LOCK: assert property (hv_oe |-> hv_id)
		else $error("high voltage on enable without id pin");
	AST_IDLE: assert property (!busy && !done |-> ce_n && oe_n && we_n && !dq_oe && !hv_id)
		else $error("pins active while idle");
	AST_DONE_ONE: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
bind fesa_host fesa_host_chk chk (.clk_sys, .reset_n, .busy, .done, .ce_n, .oe_n, .we_n,
	.hv_oe, .hv_ce, .hv_id, .addr, .dq_out, .dq_oe);
`default_nettype wire

//--- fesa_pin_cycle.sv
// Pin driver: one read, write or high-voltage cycle on the flash pins
`default_nettype none
module fesa_pin_cycle (
	input  wire logic  clk_sys,
	input  wire logic  reset_n,
	input  wire logic  clk_en,
	fesa_bus_if.pins   bus,
	output logic       ce_n,
	output logic       oe_n,
	output logic       we_n,
	output logic       hv_oe,
	output logic       hv_ce,
	output logic       hv_id,
	output logic [16:0] addr,
	output logic [7:0] dq_out,
	output logic       dq_oe,
	input  wire logic [7:0] dq_in
);
	typedef enum logic [1:0] {FESA_PC_IDLE, FESA_PC_SETUP, FESA_PC_PULSE, FESA_PC_HOLD} fesa_pc_st_t;
	typedef struct packed {
		fesa_pc_st_t          st;
		logic [7:0]           cnt;
		logic                 wr;
		logic                 ce_n, oe_n, we_n, hv_oe, hv_ce, hv_id, dq_oe, done;
		logic [16:0]          addr;
		logic [7:0]           dq_out, rdata;
	} fesa_pc_t;
	fesa_pc_t s_r, s_nxt;

	assign ce_n = s_r.ce_n;
	assign oe_n = s_r.oe_n;
	assign we_n = s_r.we_n;
	assign hv_oe = s_r.hv_oe;
	assign hv_ce = s_r.hv_ce;
	assign hv_id = s_r.hv_id;
	assign addr = s_r.addr;
	assign dq_out = s_r.dq_out;
	assign dq_oe = s_r.dq_oe;
	assign bus.done = s_r.done;
	assign bus.rdata = s_r.rdata;

	// Cycle sequencing: setup, strobe pulse well over noise width, hold
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		unique case (s_r.st)
			FESA_PC_IDLE: begin
				if (bus.req) begin
					s_nxt.addr = bus.addr;
					s_nxt.dq_out = bus.wdata;
					s_nxt.wr = bus.wr;
					s_nxt.dq_oe = bus.wr;
					s_nxt.hv_oe = bus.hv_oe;
					s_nxt.hv_ce = bus.hv_ce;
					s_nxt.hv_id = bus.hv_id;
					s_nxt.cnt = 8'(fesa_pkg::SETUP_CYC);
					s_nxt.st = FESA_PC_SETUP;
				end
			end
			FESA_PC_SETUP: begin
				// address settles before the later falling strobe
				s_nxt.ce_n = s_r.hv_ce;
				s_nxt.we_n = !s_r.wr;
				s_nxt.oe_n = s_r.wr;
				s_nxt.cnt = 8'(fesa_pkg::PULSE_CYC);
				s_nxt.st = FESA_PC_PULSE;
			end
			FESA_PC_PULSE: begin
				if (s_r.cnt == fesa_pkg::CNT_ONE) begin
					if (!s_r.wr)
						s_nxt.rdata = dq_in;
					s_nxt.we_n = 1'b1;
					s_nxt.oe_n = 1'b1;
					s_nxt.ce_n = 1'b1;
					s_nxt.st = FESA_PC_HOLD;
				end else begin
					s_nxt.cnt = s_r.cnt - fesa_pkg::CNT_ONE;
				end
			end
			FESA_PC_HOLD: begin
				// Data and high voltage held one cycle past the rising strobe
				s_nxt.dq_oe = 1'b0;
				s_nxt.hv_oe = 1'b0;
				s_nxt.hv_ce = 1'b0;
				s_nxt.hv_id = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.st = FESA_PC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{st: FESA_PC_IDLE, cnt: fesa_pkg::CNT_ZERO, wr: 1'b0, ce_n: 1'b1,
				oe_n: 1'b1, we_n: 1'b1, hv_oe: 1'b0, hv_ce: 1'b0, hv_id: 1'b0,
				dq_oe: 1'b0, done: 1'b0, addr: '0, dq_out: '0, rdata: '0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

//--- fesa_pkg.sv
// Package: constants and enums for the flash erase/status/autoselect host controller
`default_nettype none
package fesa_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	// Unlock and command addresses and bytes of the command set
	localparam logic [16:0] UNLOCK_ADDR_1 = 17'h05555;
	localparam logic [16:0] UNLOCK_ADDR_2 = 17'h02aaa;
	localparam logic [7:0]  UNLOCK_DATA_1 = 8'haa;
	localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
	localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0]  CMD_AUTOSELECT = 8'h90;
	localparam logic [7:0]  CMD_READ_RESET = 8'hf0;
	// Autoselect addresses
	localparam logic [16:0] ID_MAKER_ADDR = 17'h00000;
	localparam logic [16:0] ID_DEVICE_ADDR = 17'h00001;
	localparam logic [16:0] PROT_TOP_ADDR = 17'h1c002;
	localparam logic [16:0] PROT_BOT_ADDR = 17'h00002;
	// Bit positions of the status lines
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	// Strobe timing: noise pulses under 5 ns are ignored by the device
	localparam int CLK_PERIOD_NS = 10;
	localparam int NOISE_NS = 5;
	localparam int PULSE_MIN_NS = 50;
	localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = 1;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [2:0] STEP_ZERO = 3'h0;
	localparam logic [2:0] STEP_ONE = 3'h1;
	// Host operations
	typedef enum logic [2:0] {
		FESA_OP_ERASE, FESA_OP_READ_ID, FESA_OP_READ_PROT,
		FESA_OP_LOCK, FESA_OP_UNLOCK, FESA_OP_SW_ID
	} fesa_op_t;
endpackage
`default_nettype wire

//--- flash_erase_status_autoselect_test.sv
// Testbench: host controller against the flash device model
`default_nettype none
module flash_erase_status_autoselect_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
	localparam logic [7:0] DEVC  = 8'h3c; // Arbitrary value
	logic               clk_sys = 1'h0, reset_n = 1'h0, clk_en = 1'h1, start = 1'h0;
	logic               top_boot = 1'h0, tb;
	fesa_pkg::fesa_op_t op = fesa_pkg::FESA_OP_READ_ID;
	logic               busy, done, erase_ok, ce_n, oe_n, we_n, hv_oe, hv_ce, hv_id, dq_oe;
	logic [7:0]         result, dq_out, dq_in;
	logic [16:0]        addr;
	logic [8:0]         exp_q [$];
	int                 err_count = 0, comparisons = 0, cyc = 0;
	fesa_host dut (.clk_sys, .reset_n, .clk_en, .start, .op, .top_boot, .busy, .done, .result,
		.erase_ok, .ce_n, .oe_n, .we_n, .hv_oe, .hv_ce, .hv_id, .addr, .dq_out, .dq_oe, .dq_in);
	fesa_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC), .POLLS(6)) flash (.ce_n, .oe_n,
		.we_n, .hv_oe, .hv_ce, .hv_id, .addr, .dq_out, .dq_in);
	always #5 clk_sys = ~clk_sys;
	task automatic check(string what, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic finish_test;
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watcher: each done takes the oldest note off the queue
	always @(posedge clk_sys) begin
		logic [8:0] n;
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
		if (done === 1'h1) begin
			if (exp_q.size() == 0) check("unexpected done", 8'h00, 8'hff);
			else begin
				n = exp_q.pop_front();
				if (n[8]) check("result", n[7:0], result);
			end
		end
	end
	// One operation; poke retries start mid-op with the clock frozen a while
	task automatic run_op(fesa_pkg::fesa_op_t o, logic t, logic chk, logic [7:0] e, logic poke);
		int n;
		exp_q.push_back({chk, e});
		@(posedge clk_sys) #1;
		op = o;
		top_boot = t;
		start = 1'h1;
		@(posedge clk_sys) #1;
		start = poke;
		clk_en = !poke;
		repeat (3) @(posedge clk_sys) #1;
		clk_en = 1'h1;
		@(posedge clk_sys) #1;
		start = 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 300) begin
			@(posedge clk_sys) #1;
			n++;
		end
		// A hung operation ends the run at once
		if (n == 300) begin
			check("done wait", 8'h01, 8'h00);
			finish_test();
		end
	endtask
	initial begin
		void'($urandom(32'h6c3e));
		repeat (5) @(posedge clk_sys);
		#1 reset_n = 1'h1;
		for (int i = 0; i < 6; i++) begin
			tb = (i < 2) ? i[0] : 1'($urandom);
			run_op(fesa_pkg::FESA_OP_READ_ID, tb, 1'h1, tb ? DEVC : MAKER, i == 2);
			run_op(fesa_pkg::FESA_OP_SW_ID, tb, 1'h1, tb ? DEVC : MAKER, 1'h0);
		end
		run_op(fesa_pkg::FESA_OP_READ_PROT, 1'h1, 1'h1, 8'h00, 1'h0);
		run_op(fesa_pkg::FESA_OP_LOCK, 1'h0, 1'h0, 8'h00, 1'h0);
		run_op(fesa_pkg::FESA_OP_READ_PROT, 1'h1, 1'h1, 8'h01, 1'h0);
		run_op(fesa_pkg::FESA_OP_READ_PROT, 1'h0, 1'h1, 8'h01, 1'h0);
		run_op(fesa_pkg::FESA_OP_UNLOCK, 1'h0, 1'h0, 8'h00, 1'h0);
		run_op(fesa_pkg::FESA_OP_READ_PROT, 1'h0, 1'h1, 8'h00, 1'h0);
		// Erase is cut short by reset; full verify would run over a million cycles
		@(posedge clk_sys) #1;
		op = fesa_pkg::FESA_OP_ERASE;
		start = 1'h1;
		@(posedge clk_sys) #1;
		start = 1'h0;
		repeat (800) @(posedge clk_sys);
		#1 check("erase started", 8'h01, 8'(flash.erase_cnt));
		check("erase over", 8'h00, {7'h0, flash.erasing});
		check("busy in verify", 8'h01, {7'h0, busy});
		check("erase ok so far", 8'h01, {7'h0, erase_ok});
		reset_n = 1'h0;
		repeat (2) @(posedge clk_sys);
		#1 check("busy in reset", 8'h00, {7'h0, busy});
		reset_n = 1'h1;
		run_op(fesa_pkg::FESA_OP_READ_ID, 1'h0, 1'h1, MAKER, 1'h0);
		run_op(fesa_pkg::FESA_OP_SW_ID, 1'h0, 1'h1, MAKER, 1'h0);
		repeat (3) @(posedge clk_sys);
		check("notes left", 8'h00, 8'(exp_q.size()));
		finish_test();
	end
endmodule
`default_nettype wire
